// >>> src/can_host_port.sv
// Host access port of a stand-alone CAN controller: parallel and serial
//
// Notes on behaviour
// - Strap high: serial pins live, parallel strobes ignored
// - Strap low: parallel bus and strobes live
// - Address latched on falling address strobe
// - Store strobe low writes, read strobe drives
// - Serial frame: select, address byte, data bytes
// - Transfer sense 1 reads, 0 writes
// - Auto decrement allows many bytes, else one
// - Serial bytes travel most significant bit first
// - Serial input sampled on rising clock edge
// - Edge select 0: output changes on rising edge
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module can_host_port import host_port_pkg::*; (
    input wire logic ref_clk,                  // Device clock, 100 MHz
    input wire logic reset_n,                  // Asynchronous reset, active low
    input wire logic interface_select,         // Strap: 1 serial, 0 parallel
    input wire logic chip_select_n,            // Device select, active low
    input wire logic address_latch_strobe,     // Address strobe, high latches
    input wire logic read_strobe_n,            // Parallel read strobe, active low
    input wire logic store_strobe_n,           // Parallel write strobe, active low
    input wire logic [7:0] shared_bus_in,      // Shared bus lines, pin level
    output logic [7:0] shared_bus_out,         // Shared bus lines, driven value
    output logic shared_bus_oe,                // Shared bus lines, drive enable
    input wire logic serial_clock,             // Host serial clock
    input wire logic serial_data_input,        // Serial data in
    input wire logic transfer_sense,           // Serial direction, 1 read
    input wire logic output_edge_select,       // Serial output edge select
    output logic serial_data_output,           // Serial data out
    input wire logic [7:0] reg_addr,           // Internal register address
    input wire logic [7:0] reg_wdata,          // Internal write data
    input wire logic reg_write,                // Internal write strobe
    input wire logic reg_read,                 // Internal read strobe
    output logic [7:0] reg_rdata,              // Internal read data, next cycle
    output logic auto_decrement_enable         // Current auto decrement setting
);
    // Register space shared by both host ports and the internal port
    logic [7:0] regs [REG_COUNT];

    // Synchronised pin levels
    logic [11:0] pins_raw;
    logic [11:0] pins_sync;
    logic ale_s;
    logic rd_n_s;
    logic wr_n_s;
    logic cs_n_s;
    logic [7:0] bus_s;
    logic mode_serial;

    // Parallel port state
    logic [7:0] latched_addr;
    logic par_read;
    logic par_write;

    // Serial engine links
    logic ade_ser;
    logic [7:0] peek_addr;
    logic [7:0] peek_data;
    logic post_toggle;
    logic [7:0] post_addr;
    logic [7:0] post_data;
    logic post_toggle_s;
    logic post_toggle_q;
    logic ser_write;
    logic serial_out_w;
    logic [7:0] status;

    // Decodes an access to the status register
    function automatic logic is_status(input logic [7:0] a);
        is_status = (a == STATUS_ADDR);
    endfunction

    // Decodes an access to the configuration register
    function automatic logic is_config(input logic [7:0] a);
        is_config = (a == CFG_ADDR);
    endfunction

    // The strap and every parallel port pin pass two flops before use; the serial pins go straight to the engine
    assign pins_raw = {interface_select, address_latch_strobe, read_strobe_n,
                       store_strobe_n, chip_select_n, shared_bus_in[6:0]};

    sync_2ff #(
        .WIDTH(12),
        .INIT(12'h380)
    ) u_pin_sync (
        .clk(ref_clk),
        .reset_n(reset_n),
        .d(pins_raw),
        .q(pins_sync)
    );

    // Top bus line kept apart so its reset level stays low
    sync_2ff #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_bus7_sync (
        .clk(ref_clk),
        .reset_n(reset_n),
        .d(shared_bus_in[7]),
        .q(bus_s[7])
    );

    assign mode_serial = pins_sync[11];
    assign ale_s = pins_sync[10];
    assign rd_n_s = pins_sync[9];
    assign wr_n_s = pins_sync[8];
    assign cs_n_s = pins_sync[7];
    assign bus_s[6:0] = pins_sync[6:0];

    // Parallel accesses need the strap low and chip select low
    assign par_read = !mode_serial && !cs_n_s && !rd_n_s;
    assign par_write = !mode_serial && !cs_n_s && !wr_n_s && !ale_s;

    // Address follows the bus while the strobe is high and holds on its fall
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            latched_addr <= 8'h00;
        end else begin
            if (!mode_serial && ale_s) begin
                latched_addr <= bus_s;
            end
        end
    end

    // Serial side: configuration bit carried into the serial clock domain
    sync_2ff #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_ade_sync (
        .clk(serial_clock),
        .reset_n(reset_n),
        .d(auto_decrement_enable),
        .q(ade_ser)
    );

    // Register read port for the serial engine; contents change slowly
    assign peek_data = regs[peek_addr];

    serial_link_engine u_serial (
        .serial_clock(serial_clock),
        .reset_n(reset_n),
        .chip_select_n(chip_select_n),
        .serial_data_input(serial_data_input),
        .transfer_sense(transfer_sense),
        .output_edge_select(output_edge_select),
        .ade_sync(ade_ser),
        .peek_addr(peek_addr),
        .peek_data(peek_data),
        .post_toggle(post_toggle),
        .post_addr(post_addr),
        .post_data(post_data),
        .serial_data_output(serial_out_w)
    );

    // Toggle from the serial side marks a byte to store
    sync_2ff #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_post_sync (
        .clk(ref_clk),
        .reset_n(reset_n),
        .d(post_toggle),
        .q(post_toggle_s)
    );

    // Edge of the synchronised toggle; words are stable by then
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            post_toggle_q <= 1'b0;
        end else begin
            post_toggle_q <= post_toggle_s;
        end
    end

    assign ser_write = (post_toggle_s != post_toggle_q) && mode_serial;

    // Register writes: host port first, internal port second wins on clash
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= REG_RESET;
            end
        end else begin
            if (par_write) begin
                regs[latched_addr] <= bus_s;
            end else if (ser_write) begin
                regs[post_addr] <= post_data;
            end
            if (reg_write && !is_status(reg_addr)) begin
                regs[reg_addr] <= reg_wdata;
            end
        end
    end

    // Auto decrement setting mirrors the configuration register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            auto_decrement_enable <= CFG_RESET[ADE_BIT];
        end else if (reg_write && is_config(reg_addr)) begin
            auto_decrement_enable <= reg_wdata[ADE_BIT];
        end else if (par_write && is_config(latched_addr)) begin
            auto_decrement_enable <= bus_s[ADE_BIT];
        end else if (ser_write && is_config(post_addr)) begin
            auto_decrement_enable <= post_data[ADE_BIT];
        end
    end

    // Parallel read drives the bus while the strobe and select are low
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shared_bus_out <= 8'h00;
            shared_bus_oe <= 1'b0;
        end else begin
            shared_bus_oe <= par_read;
            shared_bus_out <= par_read ? regs[latched_addr] : 8'h00;
        end
    end

    // Status seen by the internal port
    always_comb begin
        status = 8'h00;
        status[ST_SERIAL_BIT] = mode_serial;
        status[ST_FRAME_BIT] = !cs_n_s;
        status[ST_PREAD_BIT] = par_read;
        status[ST_PWRITE_BIT] = par_write;
    end

    // Internal read data stands for one cycle after the strobe only
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= RDATA_RESET;
        end else if (reg_read) begin
            reg_rdata <= is_status(reg_addr) ? status : regs[reg_addr];
        end else begin
            reg_rdata <= RDATA_RESET;
        end
    end

    // Serial output comes from the engine's edge flops
    assign serial_data_output = serial_out_w;
endmodule
`default_nettype wire

// >>> src/host_port_pkg.sv
// Constants, states and register map for the CAN controller host access port
package host_port_pkg;
    // Widths of the register space and of one register
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 256;

    // Register offsets on the internal register port
    localparam logic [7:0] CFG_ADDR = 8'h06;      // operating_config_register
    localparam logic [7:0] STATUS_ADDR = 8'hff;   // Read-only host port status

    // Field positions
    localparam int ADE_BIT = 1;                   // auto_decrement_enable
    localparam int ST_SERIAL_BIT = 0;             // Serial port selected
    localparam int ST_FRAME_BIT = 1;              // Chip select active
    localparam int ST_PREAD_BIT = 2;              // Parallel read in progress
    localparam int ST_PWRITE_BIT = 3;             // Parallel write in progress

    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Bit counter end of a serial byte
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

    // Serial frame states
    typedef enum logic [1:0] {
        SER_ADDR = 2'b00,
        SER_DATA = 2'b01,
        SER_DONE = 2'b10
    } serial_state_e;
endpackage

// >>> src/sync_2ff.sv
// Two-flop level synchroniser with a settable reset value
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,                 // Destination clock
    input wire logic reset_n,             // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] d,       // Level from another domain
    output logic [WIDTH-1:0] q            // Synchronised level
);
    logic [WIDTH-1:0] meta;

    // First stage is read only by the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> src/serial_link_engine.sv
// Serial port engine clocked by the host serial clock
`timescale 1ns/1ns
`default_nettype none
module serial_link_engine import host_port_pkg::*; (
    input wire logic serial_clock,          // Host serial clock
    input wire logic reset_n,               // Device reset, active low
    input wire logic chip_select_n,         // Frame select, active low
    input wire logic serial_data_input,     // Serial data in
    input wire logic transfer_sense,        // 1 read, 0 write
    input wire logic output_edge_select,    // 0 rising, 1 falling output edge
    input wire logic ade_sync,              // Auto decrement, synchronised
    output logic [7:0] peek_addr,           // Register read address
    input wire logic [7:0] peek_data,       // Register read data
    output logic post_toggle,               // Flips once per written byte
    output logic [7:0] post_addr,           // Address of written byte
    output logic [7:0] post_data,           // Written byte
    output logic serial_data_output         // Serial data out
);
    serial_state_e state;
    logic frame_rst_n;
    logic [2:0] bit_cnt;
    logic [7:0] in_shift;
    logic [7:0] addr;
    logic [7:0] out_shift;
    logic read_mode;
    logic do_rise;
    logic do_fall;
    logic byte_done;
    logic [7:0] new_byte;

    // A frame ends with chip select; that or device reset clears the frame state
    assign frame_rst_n = reset_n & ~chip_select_n;
    assign byte_done = (bit_cnt == BIT_LAST);
    assign new_byte = {in_shift[6:0], serial_data_input};
    assign peek_addr = (state == SER_ADDR) ? new_byte : addr - 8'h01;

    // Frame sequencing: address byte, then data bytes
    always_ff @(posedge serial_clock or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            state <= SER_ADDR;
            bit_cnt <= 3'h0;
            in_shift <= 8'h00;
            addr <= 8'h00;
            out_shift <= 8'h00;
            read_mode <= 1'b0;
            do_rise <= 1'b0;
        end else begin
            in_shift <= new_byte;
            bit_cnt <= bit_cnt + 3'h1;
            case (state)
                SER_ADDR: begin
                    if (byte_done) begin
                        addr <= new_byte;
                        read_mode <= transfer_sense;
                        state <= SER_DATA;
                        do_rise <= transfer_sense & peek_data[7];
                        out_shift <= {peek_data[6:0], 1'b0};
                    end
                end
                SER_DATA: begin
                    if (byte_done) begin
                        if (ade_sync) begin
                            addr <= addr - 8'h01;
                            do_rise <= read_mode & peek_data[7];
                            out_shift <= {peek_data[6:0], 1'b0};
                        end else begin
                            state <= SER_DONE;
                            do_rise <= 1'b0;
                            out_shift <= 8'h00;
                        end
                    end else begin
                        do_rise <= read_mode & out_shift[7];
                        out_shift <= {out_shift[6:0], 1'b0};
                    end
                end
                SER_DONE: begin
                    do_rise <= 1'b0;
                end
                default: begin
                    state <= SER_DONE;
                end
            endcase
        end
    end

    // Completed write bytes are posted by toggle; words held until the next byte
    always_ff @(posedge serial_clock or negedge reset_n) begin
        if (!reset_n) begin
            post_toggle <= 1'b0;
            post_addr <= 8'h00;
            post_data <= 8'h00;
        end else if (state == SER_DATA && byte_done && !read_mode) begin
            post_addr <= addr;
            post_data <= new_byte;
            post_toggle <= ~post_toggle;
        end
    end

    // Falling edge copy of the output bit
    always_ff @(negedge serial_clock or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            do_fall <= 1'b0;
        end else begin
            do_fall <= do_rise;
        end
    end

    // Output edge chosen by the timing pin; both sources are flops
    assign serial_data_output = output_edge_select ? do_fall : do_rise;
endmodule
`default_nettype wire

// >>> verification/can_host_port_sva.sv
// Concurrent checks on the host access port
`timescale 1ns/1ns
`default_nettype none
module can_host_port_sva import host_port_pkg::*; (
    input wire logic ref_clk, // Device clock
    input wire logic reset_n, // Reset, active low
    input wire logic interface_select, // Port strap
    input wire logic chip_select_n, // Select, active low
    input wire logic read_strobe_n, // Read strobe
    input wire logic shared_bus_oe, // Bus enable
    input wire logic serial_clock, // Serial clock
    input wire logic transfer_sense, // Direction
    input wire logic output_edge_select, // Output edge
    input wire logic serial_data_output, // Serial out
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic auto_decrement_enable // Auto decrement
);
    logic fall_v;
    logic rise_v;
    // Serial output just before each falling edge, cleared between frames
    always_ff @(negedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            fall_v <= 1'b0;
        end else begin
            fall_v <= serial_data_output;
        end
    end
    // Serial output just before each rising edge, cleared between frames
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            rise_v <= 1'b0;
        end else begin
            rise_v <= serial_data_output;
        end
    end
    // Parallel read held with the device selected
    sequence s_rd_held;
        (!interface_select && !chip_select_n && !read_strobe_n) [*5];
    endsequence
    // Register write, then a read of the same place two cycles later
    sequence s_wr_rd;
        (reg_write && reg_addr != STATUS_ADDR) ##2 (reg_read && reg_addr == $past(reg_addr, 2));
    endsequence
    property p_serial_no_drive;
        @(posedge ref_clk) disable iff (!reset_n)
        interface_select && $past(interface_select, 3) |-> !shared_bus_oe;
    endproperty
    a_serial_no_drive: assert property (p_serial_no_drive)
        else $error("bus driven in serial mode");
    property p_deselect_quiet;
        @(posedge ref_clk) disable iff (!reset_n)
        chip_select_n [*5] |-> !shared_bus_oe;
    endproperty
    a_deselect_quiet: assert property (p_deselect_quiet)
        else $error("bus driven while deselected");
    property p_read_drive;
        @(posedge ref_clk) disable iff (!reset_n)
        s_rd_held |-> shared_bus_oe;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("bus not driven during read");
    property p_reg_rw;
        @(posedge ref_clk) disable iff (!reset_n)
        s_wr_rd |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_reg_rw: assert property (p_reg_rw)
        else $error("register read differs from last write");
    property p_ade_follows;
        @(posedge ref_clk) disable iff (!reset_n)
        (reg_write && reg_addr == CFG_ADDR) |->
            ##2 auto_decrement_enable == $past(reg_wdata[ADE_BIT], 2);
    endproperty
    a_ade_follows: assert property (p_ade_follows)
        else $error("auto decrement flag not updated");
    property p_write_quiet;
        @(posedge serial_clock) disable iff (!reset_n)
        !chip_select_n && !transfer_sense |-> !serial_data_output;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("serial output active in write frame");
    property p_rise_timing;
        @(posedge serial_clock) disable iff (!reset_n)
        !output_edge_select |-> serial_data_output == fall_v;
    endproperty
    a_rise_timing: assert property (p_rise_timing)
        else $error("serial output changed on falling edge");
    property p_fall_timing;
        @(negedge serial_clock) disable iff (!reset_n)
        output_edge_select |-> serial_data_output == rise_v;
    endproperty
    a_fall_timing: assert property (p_fall_timing)
        else $error("serial output changed on rising edge");
endmodule
bind can_host_port can_host_port_sva i_sva (.*);
`default_nettype wire

// >>> verification/host_mcu_model.sv
// Behavioural host controller driving the parallel and serial host ports
`timescale 1ns/1ns
`default_nettype none
module host_mcu_model (
    input wire logic ref_clk, // Paces parallel cycles
    output logic chip_select_n, // Select, active low
    output logic address_latch_strobe, // Address strobe
    output logic read_strobe_n, // Read strobe
    output logic store_strobe_n, // Write strobe
    output logic [7:0] shared_bus_in, // Resolved bus level
    input wire logic [7:0] shared_bus_out, // Device bus value
    input wire logic shared_bus_oe, // Device bus enable
    output logic serial_clock, // Still between frames
    output logic serial_data_input, // Data to device
    output logic transfer_sense, // Serial direction
    output logic output_edge_select, // Serial output edge
    input wire logic serial_data_output // Data from device
);
    logic [7:0] host_val;
    // Device drive wins; a released bus never shows a stale value
    assign shared_bus_in = shared_bus_oe ? shared_bus_out : host_val;
    // Unused pins rest at their inactive levels
    initial begin
        {chip_select_n, read_strobe_n, store_strobe_n} = 3'b111;
        {address_latch_strobe, serial_clock, serial_data_input} = 3'b000;
        {transfer_sense, output_edge_select} = 2'b00;
        host_val = 8'h00;
    end
    // Parallel access: address phase, then one strobe, selected or not
    task automatic par_cycle(input logic wr, sel_on, input logic [7:0] a, d,
                             output logic [7:0] q, output logic oe);
        @(posedge ref_clk);
        host_val <= a;
        address_latch_strobe <= 1'b1;
        repeat (3) @(posedge ref_clk);
        address_latch_strobe <= 1'b0;
        @(posedge ref_clk);
        host_val <= wr ? d : ~a;
        chip_select_n <= !sel_on;
        store_strobe_n <= !wr;
        read_strobe_n <= wr;
        repeat (5) @(posedge ref_clk);
        {chip_select_n, read_strobe_n, store_strobe_n} <= 3'b111;
        #1 q = shared_bus_in;
        oe = shared_bus_oe;
        repeat (2) @(posedge ref_clk);
        host_val <= ~host_val;
        repeat (4) @(posedge ref_clk);
    endtask
    // Serial frame: address byte then n data bytes; returns bits seen
    task automatic ser_frame(input logic rd, es, input logic [7:0] a, input int n,
                             input logic [15:0] wd, output logic [15:0] q);
        logic [23:0] tx;
        logic [23:0] g;
        logic got;
        tx = {a, wd};
        g = '0;
        got = 1'b0;
        @(posedge ref_clk);
        chip_select_n <= 1'b0;
        host_val <= 8'h00;
        #10 transfer_sense <= rd;
        output_edge_select <= es;
        #10;
        for (int p = 0; p < 8 * (n + 1); p++) begin
            serial_data_input <= tx[23 - p];
            #4 if (es) got = serial_data_output;
            serial_clock <= 1'b1;
            #7 if (!es) got = serial_data_output;
            serial_clock <= 1'b0;
            g = {g[22:0], got};
            #4;
        end
        #10 chip_select_n <= 1'b1;
        serial_data_input <= ~serial_data_input;
        q = es ? g[15:0] : g[16:1];
        #20;
    endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the host access port of the CAN controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", name, exp, got); end end
module testbench import host_port_pkg::*; ;
    logic ref_clk, reset_n, interface_select, chip_select_n, address_latch_strobe;
    logic read_strobe_n, store_strobe_n, shared_bus_oe, serial_clock, serial_data_input;
    logic transfer_sense, output_edge_select, serial_data_output, reg_write, reg_read;
    logic auto_decrement_enable, oe;
    logic [7:0] shared_bus_in, shared_bus_out, reg_addr, reg_wdata, reg_rdata, rv;
    logic [15:0] sq;
    int n_errors = 0;
    int num_checks = 0;
    can_host_port i_dut (.*);
    host_mcu_model i_host (.*);
    // Device clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Internal register port: one-cycle write
    task automatic reg_wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    // Internal register port: one-cycle read, data in the next cycle only
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Read one register and compare
    task automatic expect_reg(input logic [7:0] a, exp, input string name);
        reg_rd(a, rv);
        `CHK(name, exp, rv)
    endtask
    // Reset, with the strap set while reset holds and kept after it
    task automatic do_reset(input logic strap);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        interface_select <= strap;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask
    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Cuts a hang short; the whole run needs a few microseconds
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
    // Test sequence
    initial begin
        reset_n = 1'b0;
        interface_select = 1'b0;
        {reg_write, reg_read, reg_addr, reg_wdata} = '0;
        do_reset(1'b0);
        `CHK("rdata idle", 8'h00, reg_rdata)
        expect_reg(CFG_ADDR, CFG_RESET, "cfg reset");
        expect_reg(STATUS_ADDR, 8'h00, "status par");
        // Parallel writes to two places, both read back internally; 20 also read over the parallel port
        i_host.par_cycle(1'b1, 1'b1, 8'h20, 8'ha5, rv, oe);
        i_host.par_cycle(1'b1, 1'b1, 8'h21, 8'h5a, rv, oe);
        expect_reg(8'h20, 8'ha5, "par wr 20");
        expect_reg(8'h21, 8'h5a, "par wr 21");
        i_host.par_cycle(1'b0, 1'b1, 8'h20, 8'h00, rv, oe);
        `CHK("par rd data", 8'ha5, rv)
        `CHK("par rd drive", 1'b1, oe)
        i_host.par_cycle(1'b1, 1'b1, CFG_ADDR, 8'h01 << ADE_BIT, rv, oe);
        `CHK("par ade flag", 1'b1, auto_decrement_enable)
        // Strobes without select are not answered
        i_host.par_cycle(1'b1, 1'b0, 8'h22, 8'h77, rv, oe);
        expect_reg(8'h22, 8'h00, "par no select");
        i_host.par_cycle(1'b0, 1'b0, 8'h20, 8'h00, rv, oe);
        `CHK("par rd no select", 1'b0, oe)
        // Serial strap: parallel strobes are ignored
        do_reset(1'b1);
        i_host.par_cycle(1'b1, 1'b1, 8'h23, 8'h11, rv, oe);
        expect_reg(8'h23, 8'h00, "strap par wr");
        reg_rd(STATUS_ADDR, rv);
        `CHK("status serial", 1'b1, rv[ST_SERIAL_BIT])
        // Only one data byte lands while auto decrement is off
        i_host.ser_frame(1'b0, 1'b0, 8'h30, 2, 16'h5ac3, sq);
        repeat (8) @(posedge ref_clk);
        expect_reg(8'h30, 8'h5a, "ser wr 30");
        expect_reg(8'h2f, 8'h00, "ser wr 2f");
        // Auto decrement on: two bytes each way
        reg_wr(CFG_ADDR, 8'h01 << ADE_BIT);
        expect_reg(CFG_ADDR, 8'h01 << ADE_BIT, "cfg ade");
        `CHK("ade flag", 1'b1, auto_decrement_enable)
        i_host.ser_frame(1'b0, 1'b1, 8'h41, 2, 16'hc33c, sq);
        repeat (8) @(posedge ref_clk);
        expect_reg(8'h41, 8'hc3, "ser wr 41");
        expect_reg(8'h40, 8'h3c, "ser wr 40");
        // Reads with output on either clock edge
        for (int e = 0; e < 2; e++) begin
            i_host.ser_frame(1'b1, e[0], 8'h30, 1, 16'h0000, sq);
            `CHK("ser rd 30", 8'h5a, sq[7:0])
            i_host.ser_frame(1'b1, e[0], 8'h41, 2, 16'h0000, sq);
            `CHK("ser rd 41", 16'hc33c, sq)
        end
        print_verdict();
    end
endmodule
`default_nettype wire
